// file: adcd_cmd_decoder.sv
// Serial command word decoder: frame capture, decode and register access.
`timescale 1ns/1ps
`default_nettype none

module adcd_cmd_decoder (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic i_sclk,
   input wire logic i_sdi,
   input wire logic i_convert_select_pin,
   input wire logic i_capture_on_fall,
   input wire logic [15:0] i_reg_rdata,
   output logic o_reg_we,
   output logic [8:0] o_reg_addr,
   output logic [15:0] o_reg_wdata,
   output logic [1:0] o_reg_wbe,
   output logic o_rd_valid,
   output logic [31:0] o_rd_word,
   output logic o_frame_active,
   output logic [5:0] o_sclk_count,
   output logic o_cmd_done
);

   logic [adcd_pkg::PIN_N-1:0] pin_raw;
   logic [adcd_pkg::PIN_N-1:0] pin_lvl;
   logic [adcd_pkg::PIN_N-1:0] pin_rise;
   logic [adcd_pkg::PIN_N-1:0] pin_fall;

   adcd_pkg::adcd_state_t state_q;
   logic [adcd_pkg::CMD_W-1:0] shift_q;
   logic [adcd_pkg::CMD_W-1:0] cmd_q;
   logic [adcd_pkg::CNT_W-1:0] cnt_q;
   logic [8:0] addr_q;
   logic [15:0] wdata_q;
   logic [1:0] wbe_q;
   logic we_q;
   logic rd_valid_q;
   logic [31:0] rd_word_q;
   logic done_q;

   logic capture;
   logic frame_open;
   logic frame_close;
   logic [adcd_pkg::CMD_W-1:0] frame_word;
   adcd_pkg::adcd_kind_t frame_kind;
   adcd_pkg::adcd_kind_t cmd_kind_now;
   logic [15:0] cmd_data;
   logic [1:0] lanes_now;

   // Maps a command word onto the action it asks for.
   function automatic adcd_pkg::adcd_kind_t cmd_kind(
      input logic [adcd_pkg::CMD_W-1:0] w
   );
      logic [4:0] opc;
      logic [1:0] sub;
      opc = w[adcd_pkg::OPC_HI:adcd_pkg::OPC_LO];
      sub = w[adcd_pkg::SUB_HI:adcd_pkg::SUB_LO];
      cmd_kind = adcd_pkg::KIND_NOP;
      unique case (opc)
         adcd_pkg::OPC_CLEAR: begin
            cmd_kind = adcd_pkg::KIND_CLEAR;
         end
         adcd_pkg::OPC_SET: begin
            cmd_kind = adcd_pkg::KIND_SET;
         end
         adcd_pkg::OPC_READ2: begin
            cmd_kind = adcd_pkg::KIND_READ2;
         end
         adcd_pkg::OPC_READ1: begin
            cmd_kind = adcd_pkg::KIND_READ1;
         end
         adcd_pkg::OPC_WRITE: begin
            // Sub-code 11 is not a listed write and falls to no operation.
            if (sub == adcd_pkg::SUB_BOTH) begin
               cmd_kind = adcd_pkg::KIND_WR_BOTH;
            end else if (sub == adcd_pkg::SUB_UPPER) begin
               cmd_kind = adcd_pkg::KIND_WR_UPPER;
            end else if (sub == adcd_pkg::SUB_LOWER) begin
               cmd_kind = adcd_pkg::KIND_WR_LOWER;
            end
         end
         default: begin
            cmd_kind = adcd_pkg::KIND_NOP;
         end
      endcase
   endfunction : cmd_kind

   // Byte lanes that a command writes; none for reads and no operation.
   function automatic logic [1:0] kind_lanes(
      input adcd_pkg::adcd_kind_t k
   );
      kind_lanes = 2'h0;
      unique case (k)
         adcd_pkg::KIND_CLEAR, adcd_pkg::KIND_SET,
         adcd_pkg::KIND_WR_BOTH: begin
            kind_lanes = adcd_pkg::LANE_BOTH;
         end
         adcd_pkg::KIND_WR_UPPER: begin
            kind_lanes = adcd_pkg::LANE_UPPER;
         end
         adcd_pkg::KIND_WR_LOWER: begin
            kind_lanes = adcd_pkg::LANE_LOWER;
         end
         adcd_pkg::KIND_READ2, adcd_pkg::KIND_READ1,
         adcd_pkg::KIND_NOP: begin
            kind_lanes = 2'h0;
         end
      endcase
   endfunction : kind_lanes

   // Serial pins are asynchronous to the system clock.
   assign pin_raw[adcd_pkg::PIN_SDI] = i_sdi;
   assign pin_raw[adcd_pkg::PIN_SCLK] = i_sclk;
   assign pin_raw[adcd_pkg::PIN_SEL] = i_convert_select_pin;

   adcd_pin_sync u_sync (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_pin(pin_raw),
      .o_level(pin_lvl),
      .o_rise(pin_rise),
      .o_fall(pin_fall)
   );

   // Bits enter only on an edge of the host serial clock.
   assign capture = (state_q == adcd_pkg::ST_FRAME) &&
      (i_capture_on_fall ? pin_fall[adcd_pkg::PIN_SCLK]
                         : pin_rise[adcd_pkg::PIN_SCLK]);
   assign frame_open = (state_q == adcd_pkg::ST_IDLE) &&
      pin_fall[adcd_pkg::PIN_SEL];
   assign frame_close = (state_q == adcd_pkg::ST_FRAME) &&
      pin_rise[adcd_pkg::PIN_SEL];

   // A frame with fewer than 32 edges hands on an all-zero word.
   assign frame_word = (cnt_q >= adcd_pkg::CNT_FULL) ? shift_q
                                                    : adcd_pkg::CMD_RESET;
   assign frame_kind = cmd_kind(frame_word);
   assign cmd_kind_now = cmd_kind(cmd_q);
   assign cmd_data = cmd_q[adcd_pkg::DAT_HI:adcd_pkg::DAT_LO];
   assign lanes_now = kind_lanes(cmd_kind_now);

   // Frame sequencing.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_q <= adcd_pkg::ST_IDLE;
      end else begin
         unique case (state_q)
            adcd_pkg::ST_IDLE: begin
               if (frame_open) begin
                  state_q <= adcd_pkg::ST_FRAME;
               end
            end
            adcd_pkg::ST_FRAME: begin
               if (frame_close) begin
                  state_q <= adcd_pkg::ST_LOOK;
               end
            end
            adcd_pkg::ST_LOOK: begin
               state_q <= adcd_pkg::ST_ISSUE;
            end
            adcd_pkg::ST_ISSUE: begin
               state_q <= adcd_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Input shift register; older bits fall off the top, the last 32 remain.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         shift_q <= adcd_pkg::CMD_RESET;
      end else if (frame_open) begin
         shift_q <= adcd_pkg::CMD_RESET;
      end else if (capture) begin
         shift_q <= {shift_q[adcd_pkg::CMD_W-2:0],
                     pin_lvl[adcd_pkg::PIN_SDI]};
      end
   end

   // Capture edge counter, held at its saturation value in long frames.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_q <= adcd_pkg::CNT_RESET;
      end else if (frame_open) begin
         cnt_q <= adcd_pkg::CNT_RESET;
      end else if (capture && (cnt_q != adcd_pkg::CNT_SAT)) begin
         cnt_q <= cnt_q + 6'h01;
      end
   end

   // Command register, emptied at each frame start.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cmd_q <= adcd_pkg::CMD_RESET;
      end else if (frame_open) begin
         cmd_q <= adcd_pkg::CMD_RESET;
      end else if (frame_close) begin
         cmd_q <= frame_word;
      end
   end

   // Register address of the command that the frame delivered.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         addr_q <= adcd_pkg::ADDR_RESET;
      end else if (frame_close) begin
         if (frame_kind == adcd_pkg::KIND_READ1) begin
            addr_q <= frame_word[adcd_pkg::ADR_HI:adcd_pkg::ADR_LO];
         end else begin
            // Pair commands act on the even address of the pair.
            addr_q <= {frame_word[adcd_pkg::ADR_HI:adcd_pkg::ADR_LO+1],
                       1'b0};
         end
      end
   end

   // Strobe for any command that writes at least one byte lane.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         we_q <= 1'b0;
      end else begin
         we_q <= (state_q == adcd_pkg::ST_LOOK) &&
            (lanes_now != 2'h0);
      end
   end

   // Byte lanes of the write now being issued.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wbe_q <= 2'h0;
      end else if ((state_q == adcd_pkg::ST_LOOK) &&
                   (lanes_now != 2'h0)) begin
         wbe_q <= lanes_now;
      end
   end

   // Write data; the map presents the addressed pair while in look.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wdata_q <= adcd_pkg::HALF_RESET;
      end else if (state_q == adcd_pkg::ST_LOOK) begin
         if (cmd_kind_now == adcd_pkg::KIND_CLEAR) begin
            wdata_q <= i_reg_rdata & ~cmd_data;
         end else if (cmd_kind_now == adcd_pkg::KIND_SET) begin
            wdata_q <= i_reg_rdata | cmd_data;
         end else if (lanes_now != 2'h0) begin
            wdata_q <= cmd_data;
         end
      end
   end

   // Marks the following frame's output word as register data.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rd_valid_q <= 1'b0;
      end else if (state_q == adcd_pkg::ST_LOOK) begin
         rd_valid_q <= (cmd_kind_now == adcd_pkg::KIND_READ2) ||
            (cmd_kind_now == adcd_pkg::KIND_READ1);
      end
   end

   // Output word for the following frame, set by this frame's command.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rd_word_q <= adcd_pkg::WORD_RESET;
      end else if (state_q == adcd_pkg::ST_LOOK) begin
         if (cmd_kind_now == adcd_pkg::KIND_READ2) begin
            rd_word_q <= {i_reg_rdata, 16'h0000};
         end else if (cmd_kind_now == adcd_pkg::KIND_READ1) begin
            // An odd address selects the upper byte of the pair.
            rd_word_q <= {(addr_q[0] ? i_reg_rdata[15:8]
                                     : i_reg_rdata[7:0]),
                          24'h00_0000};
         end else begin
            rd_word_q <= adcd_pkg::WORD_RESET;
         end
      end
   end

   // One-cycle completion strobe, aligned with the write strobe.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         done_q <= 1'b0;
      end else begin
         done_q <= (state_q == adcd_pkg::ST_LOOK);
      end
   end

   assign o_reg_we = we_q;
   assign o_reg_addr = addr_q;
   assign o_reg_wdata = wdata_q;
   assign o_reg_wbe = wbe_q;
   assign o_rd_valid = rd_valid_q;
   assign o_rd_word = rd_word_q;
   assign o_frame_active = (state_q == adcd_pkg::ST_FRAME);
   assign o_sclk_count = cnt_q;
   assign o_cmd_done = done_q;

endmodule : adcd_cmd_decoder

`default_nettype wire

// file: adcd_cmd_decoder_properties.sv
// Concurrent checks on the ports of the serial command decoder.
`timescale 1ns/1ps
`default_nettype none

module adcd_cmd_decoder_properties (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic i_convert_select_pin,
   input wire logic o_reg_we,
   input wire logic [8:0] o_reg_addr,
   input wire logic [1:0] o_reg_wbe,
   input wire logic o_rd_valid,
   input wire logic [31:0] o_rd_word,
   input wire logic o_frame_active,
   input wire logic [5:0] o_sclk_count,
   input wire logic o_cmd_done
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);

   a_we_with_done: assert property (o_reg_we |-> o_cmd_done)
      else $error("write strobe without command done");
   a_we_one_cycle: assert property (o_reg_we |=> !o_reg_we)
      else $error("write strobe longer than one cycle");
   a_addr_even: assert property (o_reg_we |-> !o_reg_addr[0])
      else $error("write to an odd pair address");
   a_lane_legal: assert property (o_reg_we |-> o_reg_wbe != 2'h0)
      else $error("write strobe with no byte lane");
   a_exec_sel_high: assert property (o_reg_we |->
      i_convert_select_pin && $past(i_convert_select_pin, 4))
      else $error("write before the select rising edge");
   a_quiet_in_frame: assert property (o_frame_active |->
      !o_reg_we && !o_cmd_done)
      else $error("command executed inside an open frame");
   a_count_bound: assert property (o_sclk_count <= 6'h21)
      else $error("edge count beyond saturation");
   a_short_reject: assert property ($fell(o_frame_active) &&
      o_sclk_count < 6'h20 |-> !o_reg_we [*3])
      else $error("write after a short frame");
   a_frame_count_zero: assert property ($rose(o_frame_active) |->
      o_sclk_count == 6'h00)
      else $error("edge count not cleared at frame start");
   a_rd_zero_fill: assert property (o_rd_valid |->
      o_rd_word[15:0] == 16'h0000)
      else $error("read word low half not zero");
   a_rd_no_write: assert property ($rose(o_rd_valid) |-> !o_reg_we)
      else $error("read command caused a write");
endmodule : adcd_cmd_decoder_properties

bind adcd_cmd_decoder adcd_cmd_decoder_properties adcd_cmd_decoder_props (
   .i_clk_sys(i_clk_sys),
   .i_rst_b(i_rst_b),
   .i_convert_select_pin(i_convert_select_pin),
   .o_reg_we(o_reg_we),
   .o_reg_addr(o_reg_addr),
   .o_reg_wbe(o_reg_wbe),
   .o_rd_valid(o_rd_valid),
   .o_rd_word(o_rd_word),
   .o_frame_active(o_frame_active),
   .o_sclk_count(o_sclk_count),
   .o_cmd_done(o_cmd_done)
);

`default_nettype wire

// file: adcd_cmd_decoder_tb_top.sv
// Self-checking bench for the serial command decoder.
`timescale 1ns/1ps
`default_nettype none

module adcd_cmd_decoder_tb_top;
   logic clk_sys;
   logic rst_b;
   logic fall_mode;
   logic sclk;
   logic sdi;
   logic sel;
   logic [15:0] reg_rdata;
   logic reg_we;
   logic [8:0] reg_addr;
   logic [15:0] reg_wdata;
   logic [1:0] reg_wbe;
   logic rd_valid;
   logic [31:0] rd_word;
   logic [15:0] map_q [0:255];
   int n_fail = 0;
   int cmp_count = 0;
   int cycles = 0;

   adcd_host_model adcd_host_model_inst (.i_clk_sys(clk_sys),
      .i_capture_on_fall(fall_mode), .o_sclk(sclk), .o_sdi(sdi),
      .o_sel(sel));

   adcd_cmd_decoder adcd_cmd_decoder_inst (.i_clk_sys(clk_sys),
      .i_rst_b(rst_b), .i_sclk(sclk), .i_sdi(sdi),
      .i_convert_select_pin(sel), .i_capture_on_fall(fall_mode),
      .i_reg_rdata(reg_rdata), .o_reg_we(reg_we), .o_reg_addr(reg_addr),
      .o_reg_wdata(reg_wdata), .o_reg_wbe(reg_wbe), .o_rd_valid(rd_valid),
      .o_rd_word(rd_word), .o_frame_active(), .o_sclk_count(),
      .o_cmd_done());

   // Register map: each entry is a pair, even byte in the low lane.
   assign reg_rdata = map_q[reg_addr[8:1]];
   always @(posedge clk_sys) begin
      if (reg_we && reg_wbe[1]) map_q[reg_addr[8:1]][15:8] <= reg_wdata[15:8];
      if (reg_we && reg_wbe[0]) map_q[reg_addr[8:1]][7:0] <= reg_wdata[7:0];
   end

   task automatic give_verdict;
      if (n_fail == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : give_verdict

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic chk_map(input int idx, input logic [15:0] exp);
      check("map pair", {16'h0000, map_q[idx]}, {16'h0000, exp});
   endtask : chk_map

   function automatic logic [31:0] mk(input logic [4:0] opc,
      input logic [1:0] sub, input logic [7:0] adr, input logic [15:0] dat);
      return {opc, sub, 1'b0, adr, dat};
   endfunction : mk

   task automatic frame(input logic [31:0] w, input int n);
      adcd_host_model_inst.send_frame(w, n);
   endtask : frame

   task automatic t_writes;
      frame(mk(5'h1A, 2'h0, 8'h05, 16'hABCD), 32);
      chk_map(2, 16'hABCD);
      frame(mk(5'h1A, 2'h1, 8'h07, 16'h1234), 32);
      chk_map(3, 16'h1200);
      frame(mk(5'h1A, 2'h2, 8'h06, 16'h5678), 32);
      chk_map(3, 16'h1278);
   endtask : t_writes

   task automatic t_clear_set;
      frame(mk(5'h18, 2'h0, 8'h05, 16'h00FF), 32);
      chk_map(2, 16'hAB00);
      frame(mk(5'h1B, 2'h3, 8'h04, 16'h0F0F), 32);
      chk_map(2, 16'hAF0F);
   endtask : t_clear_set

   task automatic t_reads;
      frame(mk(5'h19, 2'h0, 8'h05, 16'h0000), 32);
      check("rd_valid", {31'h0, rd_valid}, 32'h0000_0001);
      check("rd_word", rd_word, 32'hAF0F_0000);
      frame(mk(5'h09, 2'h0, 8'h05, 16'h0000), 32);
      check("rd_word", rd_word, 32'hAF00_0000);
      frame(mk(5'h09, 2'h0, 8'h04, 16'h0000), 32);
      check("rd_word", rd_word, 32'h0F00_0000);
      frame(32'h0000_0000, 32);
      check("rd_valid", {31'h0, rd_valid}, 32'h0000_0000);
      chk_map(2, 16'hAF0F);
      frame(mk(5'h19, 2'h0, 8'h04, 16'h0000), 32);
      frame(mk(5'h19, 2'h0, 8'h04, 16'h0000), 20);
      check("rd_valid", {31'h0, rd_valid}, 32'h0000_0000);
   endtask : t_reads

   task automatic t_rejects;
      frame(mk(5'h1A, 2'h3, 8'h02, 16'h9999), 32);
      chk_map(1, 16'h0000);
      frame(mk(5'h1F, 2'h0, 8'h02, 16'h9999), 32);
      chk_map(1, 16'h0000);
      frame(mk(5'h1A, 2'h0, 8'h02, 16'h1111), 31);
      chk_map(1, 16'h0000);
      frame(mk(5'h1A, 2'h0, 8'h02, 16'h2222), 40);
      chk_map(1, 16'h2222);
   endtask : t_rejects

   task automatic t_fall_mode;
      @(negedge clk_sys);
      fall_mode = 1'b1;
      frame(mk(5'h1A, 2'h0, 8'h09, 16'h5A5A), 32);
      chk_map(4, 16'h5A5A);
      fall_mode = 1'b0;
   endtask : t_fall_mode

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   initial begin
      rst_b = 1'b0;
      fall_mode = 1'b0;
      for (int i = 0; i < 256; i++) map_q[i] = 16'h0000;
      repeat (8) @(negedge clk_sys);
      rst_b = 1'b1;
      repeat (8) @(negedge clk_sys);
      t_writes();
      t_clear_set();
      t_reads();
      t_rejects();
      t_fall_mode();
      give_verdict();
   end

   // Sixteen frames of about 300 cycles each fit well inside the ceiling.
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 12000) begin
         n_fail++;
         give_verdict();
      end
   end
endmodule : adcd_cmd_decoder_tb_top

`default_nettype wire

// file: adcd_host_model.sv
// Host controller model that shifts command frames into the decoder.
`timescale 1ns/1ps
`default_nettype none

module adcd_host_model (
   input wire logic i_clk_sys,
   input wire logic i_capture_on_fall,
   output logic o_sclk,
   output logic o_sdi,
   output logic o_sel
);
   initial begin
      o_sclk = 1'b0;
      o_sdi = 1'b0;
      o_sel = 1'b1;
   end

   // Each serial clock phase lasts four system cycles, a 200 ns period.
   task automatic half;
      repeat (4) @(negedge i_clk_sys);
   endtask : half

   // Bits above 31 are filler ones, so only the last 32 form the word.
   task automatic send_frame(input logic [31:0] w, input int n);
      logic b;
      b = 1'b0;
      o_sel = 1'b0;
      half();
      for (int i = n - 1; i >= 0; i--) begin
         b = (i < 32) ? w[i] : 1'b1;
         if (i_capture_on_fall) begin
            // Launch on the rising edge so the bit stands at the fall.
            o_sclk = 1'b1;
            o_sdi = b;
            half();
            o_sclk = 1'b0;
            half();
         end else begin
            o_sdi = b;
            half();
            o_sclk = 1'b1;
            half();
            o_sclk = 1'b0;
         end
      end
      half();
      // A released data line shows the inverse of its last bit.
      o_sdi = ~b;
      o_sel = 1'b1;
      repeat (24) @(negedge i_clk_sys);
   endtask : send_frame
endmodule : adcd_host_model

`default_nettype wire

// file: adcd_pin_sync.sv
// Three-stage synchroniser with filtered level and edge pulses per pin.
`timescale 1ns/1ps
`default_nettype none

module adcd_pin_sync (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic [adcd_pkg::PIN_N-1:0] i_pin,
   output logic [adcd_pkg::PIN_N-1:0] o_level,
   output logic [adcd_pkg::PIN_N-1:0] o_rise,
   output logic [adcd_pkg::PIN_N-1:0] o_fall
);

   logic [adcd_pkg::PIN_N-1:0] s1_q;
   logic [adcd_pkg::PIN_N-1:0] s2_q;
   logic [adcd_pkg::PIN_N-1:0] s3_q;
   logic [adcd_pkg::PIN_N-1:0] lvl_q;
   logic [adcd_pkg::PIN_N-1:0] rise_q;
   logic [adcd_pkg::PIN_N-1:0] fall_q;

   genvar g;
   generate
      for (g = 0; g < adcd_pkg::PIN_N; g++) begin : g_pin
         always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
            if (!i_rst_b) begin
               s1_q[g] <= 1'b0;
               s2_q[g] <= 1'b0;
               s3_q[g] <= 1'b0;
               lvl_q[g] <= 1'b0;
               rise_q[g] <= 1'b0;
               fall_q[g] <= 1'b0;
            end else begin
               s1_q[g] <= i_pin[g];
               s2_q[g] <= s1_q[g];
               s3_q[g] <= s2_q[g];
               // A change counts only once stages two and three agree.
               if (s2_q[g] == s3_q[g]) begin
                  lvl_q[g] <= s3_q[g];
               end
               rise_q[g] <= (s2_q[g] == s3_q[g]) && s3_q[g] && !lvl_q[g];
               fall_q[g] <= (s2_q[g] == s3_q[g]) && !s3_q[g] && lvl_q[g];
            end
         end
      end
   endgenerate

   assign o_level = lvl_q;
   assign o_rise = rise_q;
   assign o_fall = fall_q;

endmodule : adcd_pin_sync

`default_nettype wire

// file: adcd_pkg.sv
// Constants and types shared by the serial command decoder.
// Behaviour
// - Command bits captured only on host serial clock.
// - Operations move one byte or two bytes.
// - Half-word commands force address bit zero low.
// - All-zero and unlisted commands do nothing.
// - Opcode 11000 clears bits marked one.
// - Opcode 11011 sets bits marked one.
// - Opcode 11001 returns sixteen bits next frame.
// - Opcode 01001 returns eight bits next frame.
// - Write sub-code 00 stores both bytes.
// - Write sub-code 01 stores upper byte only.
// - Write sub-code 10 stores lower byte only.
// - Commands execute at the select rising edge.
// - Short frame rejected as no operation.
// - Long frame uses last 32 bits shifted.
// - Frame start clears command register to zero.
// - Read data sits high, remaining bits zero.
`default_nettype none

package adcd_pkg;

   localparam int CMD_W = 32;
   localparam int CNT_W = 6;
   localparam int PIN_N = 3;

   // Positions inside the synchronised pin vector.
   localparam int PIN_SDI = 0;
   localparam int PIN_SCLK = 1;
   localparam int PIN_SEL = 2;

   // Command word fields.
   localparam int OPC_HI = 31;
   localparam int OPC_LO = 27;
   localparam int SUB_HI = 26;
   localparam int SUB_LO = 25;
   localparam int ADR_HI = 24;
   localparam int ADR_LO = 16;
   localparam int DAT_HI = 15;
   localparam int DAT_LO = 0;

   localparam logic [4:0] OPC_CLEAR = 5'h18;
   localparam logic [4:0] OPC_READ2 = 5'h19;
   localparam logic [4:0] OPC_READ1 = 5'h09;
   localparam logic [4:0] OPC_WRITE = 5'h1A;
   localparam logic [4:0] OPC_SET = 5'h1B;

   localparam logic [1:0] SUB_BOTH = 2'h0;
   localparam logic [1:0] SUB_UPPER = 2'h1;
   localparam logic [1:0] SUB_LOWER = 2'h2;

   localparam logic [1:0] LANE_BOTH = 2'h3;
   localparam logic [1:0] LANE_UPPER = 2'h2;
   localparam logic [1:0] LANE_LOWER = 2'h1;

   // Edge count of an optimal frame and the saturation point.
   localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;
   localparam logic [CNT_W-1:0] CNT_SAT = 6'h21;

   // Values after reset and at frame start.
   localparam logic [CMD_W-1:0] CMD_RESET = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
   localparam logic [15:0] HALF_RESET = 16'h0000;
   localparam logic [8:0] ADDR_RESET = 9'h000;
   localparam logic [CMD_W-1:0] WORD_RESET = 32'h0000_0000;
   localparam logic [PIN_N-1:0] PIN_RESET = 3'h0;

   typedef enum logic [2:0] {
      KIND_NOP = 3'b000,
      KIND_CLEAR = 3'b001,
      KIND_SET = 3'b010,
      KIND_WR_BOTH = 3'b011,
      KIND_WR_UPPER = 3'b100,
      KIND_WR_LOWER = 3'b101,
      KIND_READ2 = 3'b110,
      KIND_READ1 = 3'b111
   } adcd_kind_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FRAME = 2'b01,
      ST_LOOK = 2'b10,
      ST_ISSUE = 2'b11
   } adcd_state_t;

endpackage : adcd_pkg

`default_nettype wire
